//--- tdr_map.vh
// register offsets, field positions and codes of the debug readout block
`ifndef TDR_MAP_VH
`define TDR_MAP_VH

// register offsets on the apb bus
`define TDR_PTR_OFS 12'h000
`define TDR_DATA_OFS 12'h004

// read pointer layout and reset value
`define TDR_PTR_RST 32'h0000_0000
`define TDR_PTR_STEP 32'h0000_0004
`define TDR_PTR_ENT_MSB 15
`define TDR_PTR_ENT_LSB 4
`define TDR_PTR_WRD_MSB 3
`define TDR_PTR_WRD_LSB 2
`define TDR_PTR_HI_MSB 31
`define TDR_PTR_HI_LSB 16

// word positions inside one entry
`define TDR_WORD_FIRST 2'h0
`define TDR_WORD_SECOND 2'h1
`define TDR_WORD_LAST 2'h3

// flag fields common to every returned word
`define TDR_INFO_MSB 3
`define TDR_INFO_LSB 2
`define TDR_PINV_BIT 1
`define TDR_POS_LO_BIT 0
`define TDR_POS_HI_BIT 3

// word position codes
`define TDR_POS_MID 2'h0
`define TDR_POS_ENT_FIRST 2'h1
`define TDR_POS_ENT_LAST 2'h2
`define TDR_POS_TLB_FIRST 2'h3

// first word: lookup virtual address
`define TDR_VA_MSB 31
`define TDR_VA_LSB 4

// second word: configuration fields
`define TDR_PRIV_LSB 28
`define TDR_INST_LSB 26
`define TDR_NS_LSB 24
`define TDR_MATTR_LSB 17
`define TDR_SH_LSB 14
`define TDR_RA_LSB 12
`define TDR_WA_LSB 10
`define TDR_BSU_LSB 8
`define TDR_PGSZ_LSB 4

// page size codes
`define TDR_PG_4K 3'h0
`define TDR_PG_64K 3'h1
`define TDR_PG_2M 3'h3
`define TDR_PG_512M 3'h5
`define TDR_PG_1G 3'h6

`endif

//--- tdr_debug_readout.v
// apb debug readout of tlb entries through a pointer and a data register
`timescale 1ns/1ps
// Summary of operation
// (RQ1) word 1 carries the lookup virtual address in bits 31 to 4
// (RQ2) bit 2 of every word reports 0 valid, 1 invalid word information; bit 3 carries the position code high bit for an in-bounds pointer, else 0
// (RQ3) bit 1 of every word is 0 for a valid pointer, 1 otherwise
// (RQ4) every word read with an in-bounds pointer carries a position code: middle, entry first, entry last, tlb first
// (RQ5) word 2 returns privilege, instruction and nonsecure configs at 29:24
// (RQ6) word 2 returns the 3-bit shareability config at bits 16 to 14
// (RQ7) word 2 returns read allocate at 13:12 and write allocate at 11:10
// (RQ8) word 2 returns barrier shareability attributes at bits 9 to 8
// (RQ9) word 2 encodes page size in bits 6 to 4 with fixed codes
// (RQ10) word 2 returns the 7-bit memory attributes at bits 23 to 17
// (RQ11) reserved bits 31:30 and 7 of word 2 read as zero
// (RQ12) each data read returns the pointed word then advances pointer by four
// (RQ13) the two low pointer bits read zero and ignore writes
// (RQ14) a data read with an out of bounds pointer gets an apb error
// (RQ15) host loads entry index in bits 15:4, word in bits 3:2
`include "tdr_map.vh"

module tdr_debug_readout #(
	parameter TLB_ENTRIES = 128,
	parameter ENT_AW = 7
) (
	// clock and reset
	input wire i_core_clk,
	input wire i_resetn,
	// apb slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr,
	// entry fill port from the translation logic
	input wire i_fill_we,
	input wire [ENT_AW-1:0] i_fill_index,
	input wire i_fill_valid,
	input wire [27:0] i_fill_va,
	input wire [1:0] i_fill_privilege_config,
	input wire [1:0] i_fill_instruction_config,
	input wire [1:0] i_fill_nonsecure_config,
	input wire [6:0] i_fill_mem_attr,
	input wire [2:0] i_fill_shareability_config,
	input wire [1:0] i_fill_read_allocate_config,
	input wire [1:0] i_fill_write_allocate_config,
	input wire [1:0] i_fill_barrier_share_attr,
	input wire [2:0] i_fill_page_size
);

	// packed configuration width stored per entry
	localparam CFG_W = 25;

	// entry storage
	reg [27:0] va_mem [0:TLB_ENTRIES-1];
	reg [CFG_W-1:0] cfg_mem [0:TLB_ENTRIES-1];
	reg [TLB_ENTRIES-1:0] ent_valid_r;

	// register state
	reg [31:0] ptr_r;
	reg [31:0] ptr_nxt;
	reg [31:0] prdata_r;
	reg pslverr_r;

	// decoded pointer and word
	wire [11:0] ptr_ent;
	wire [1:0] ptr_wrd;
	wire ptr_oob;
	wire [ENT_AW-1:0] ent_idx;
	wire [27:0] cur_va;
	wire [CFG_W-1:0] cur_cfg;
	wire cur_valid;
	wire [1:0] cur_pos;
	reg [31:0] word_val;
	reg [31:0] rd_val;
	reg rd_err;

	// apb phase decode
	wire setup_ph;
	wire access_ph;
	wire hit_ptr;
	wire hit_data;

	// position code of a word inside the buffer
	function [1:0] pos_code;
		input [11:0] ent;
		input [1:0] wrd;
		begin
			if (wrd == `TDR_WORD_FIRST && ent == 12'h000)
				pos_code = `TDR_POS_TLB_FIRST;
			else if (wrd == `TDR_WORD_FIRST)
				pos_code = `TDR_POS_ENT_FIRST;
			else if (wrd == `TDR_WORD_LAST)
				pos_code = `TDR_POS_ENT_LAST;
			else
				pos_code = `TDR_POS_MID;
		end
	endfunction

	// apb decode: the bus never waits, data is formed in the setup phase
	assign setup_ph = i_psel & ~i_penable;
	assign access_ph = i_psel & i_penable;
	assign hit_ptr = (i_paddr == `TDR_PTR_OFS);
	assign hit_data = (i_paddr == `TDR_DATA_OFS);
	assign o_pready = 1'b1;
	assign o_prdata = prdata_r;
	assign o_pslverr = pslverr_r & access_ph;

	// pointer fields and bounds check
	assign ptr_ent = ptr_r[`TDR_PTR_ENT_MSB:`TDR_PTR_ENT_LSB];
	assign ptr_wrd = ptr_r[`TDR_PTR_WRD_MSB:`TDR_PTR_WRD_LSB];
	assign ptr_oob = (|ptr_r[`TDR_PTR_HI_MSB:`TDR_PTR_HI_LSB]) |
		(ptr_ent >= TLB_ENTRIES);
	assign ent_idx = ptr_ent[ENT_AW-1:0];

	// entry fetch; out of bounds pointers read entry zero, masked below
	assign cur_va = va_mem[ptr_oob ? {ENT_AW{1'b0}} : ent_idx];
	assign cur_cfg = cfg_mem[ptr_oob ? {ENT_AW{1'b0}} : ent_idx];
	assign cur_valid = ~ptr_oob & ent_valid_r[ent_idx];

	// position code of the word under the pointer, split over two bits
	assign cur_pos = pos_code(ptr_ent, ptr_wrd);

	// fill port writes the entry arrays
	always @(posedge i_core_clk) begin
		if (i_fill_we) begin
			va_mem[i_fill_index] <= i_fill_va;
			cfg_mem[i_fill_index] <= {i_fill_privilege_config,
				i_fill_instruction_config, i_fill_nonsecure_config,
				i_fill_mem_attr, i_fill_shareability_config,
				i_fill_read_allocate_config,
				i_fill_write_allocate_config,
				i_fill_barrier_share_attr, i_fill_page_size};
		end
	end

	// entry valid bits, cleared at reset
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ent_valid_r <= {TLB_ENTRIES{1'b0}};
		end else if (i_fill_we) begin
			ent_valid_r[i_fill_index] <= i_fill_valid;
		end
	end

	// format the word under the pointer
	always @* begin
		word_val = 32'h0000_0000;
		case (ptr_wrd)
			`TDR_WORD_FIRST: begin
				word_val[`TDR_VA_MSB:`TDR_VA_LSB] = cur_va; // RQ1
			end
			`TDR_WORD_SECOND: begin
				// reserved bits 31:30 and 7 stay zero
				word_val[`TDR_PRIV_LSB+1:`TDR_PRIV_LSB] = cur_cfg[24:23]; // RQ5
				word_val[`TDR_INST_LSB+1:`TDR_INST_LSB] = cur_cfg[22:21]; // RQ5
				word_val[`TDR_NS_LSB+1:`TDR_NS_LSB] = cur_cfg[20:19]; // RQ5
				word_val[`TDR_MATTR_LSB+6:`TDR_MATTR_LSB] = cur_cfg[18:12]; // RQ10
				word_val[`TDR_SH_LSB+2:`TDR_SH_LSB] = cur_cfg[11:9]; // RQ6
				word_val[`TDR_RA_LSB+1:`TDR_RA_LSB] = cur_cfg[8:7]; // RQ7
				word_val[`TDR_WA_LSB+1:`TDR_WA_LSB] = cur_cfg[6:5]; // RQ7
				word_val[`TDR_BSU_LSB+1:`TDR_BSU_LSB] = cur_cfg[4:3]; // RQ8
				word_val[`TDR_PGSZ_LSB+2:`TDR_PGSZ_LSB] = cur_cfg[2:0]; // RQ9
			end
			default: begin
				word_val = 32'h0000_0000; // RQ11
			end
		endcase
		// status flags shared by every word
		word_val[`TDR_INFO_MSB:`TDR_INFO_LSB] = {1'b0, ~cur_valid}; // RQ2
		word_val[`TDR_PINV_BIT] = ptr_oob; // RQ3
		word_val[`TDR_POS_LO_BIT] = cur_pos[0]; // RQ4
		word_val[`TDR_POS_HI_BIT] = cur_pos[1]; // RQ4
	end

	// read mux and error decision for the current address
	always @* begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (hit_ptr) begin
			rd_val = ptr_r;
		end else if (hit_data) begin
			rd_err = ptr_oob; // RQ14
			if (ptr_oob) begin
				// a bad pointer returns no payload, only the invalid flags,
				// so nothing of entry zero leaks out on an error read
				rd_val[`TDR_INFO_LSB] = 1'b1; // RQ2
				rd_val[`TDR_PINV_BIT] = 1'b1; // RQ3
			end else begin
				rd_val = word_val; // RQ12
			end
		end
	end

	// pointer next value: host write or post-read advance
	always @* begin
		ptr_nxt = ptr_r;
		if (access_ph & i_pwrite & hit_ptr) begin
			ptr_nxt = {i_pwdata[31:2], 2'b00}; // RQ13
		end else if (access_ph & ~i_pwrite & hit_data) begin
			ptr_nxt = ptr_r + `TDR_PTR_STEP; // RQ12
		end
	end

	// pointer register
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ptr_r <= `TDR_PTR_RST;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	// read data and error flop, loaded in the setup phase
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r <= i_pwrite ? 32'h0000_0000 : rd_val;
			pslverr_r <= ~i_pwrite & rd_err; // RQ14
		end
	end

endmodule // tdr_debug_readout

//--- tdr_checker.sv
// apb-side assertions of the debug readout
`timescale 1ns/1ps
module tdr_checker (
	// clock and reset
	input wire i_core_clk,
	input wire i_resetn,
	// apb
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] o_prdata,
	input wire o_pready,
	input wire o_pslverr
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	// setup phase of a read
	wire rd_setup = i_psel && !i_penable && !i_pwrite;
	a_ready_high: assert property (o_pready)
		else $error("pready low");
	a_err_access: assert property (
		o_pslverr |-> i_psel && i_penable && !i_pwrite)
		else $error("error outside read access");
	a_err_addr: assert property (o_pslverr |-> i_paddr == 12'h004)
		else $error("error off data register");
	a_err_flags: assert property (
		o_pslverr |-> o_prdata == 32'h0000_0006)
		else $error("error read not flags only");
	a_ptr_low: assert property (
		rd_setup && i_paddr == 12'h000 |=> o_prdata[1:0] == 2'h0)
		else $error("pointer low bits set");
	a_data_hold: assert property (
		!(i_psel && !i_penable) |=> $stable(o_prdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (
		rd_setup && i_paddr != 12'h000 && i_paddr != 12'h004
		|=> o_prdata == 32'h0) else $error("unmapped read not zero");
	a_ptr_flag: assert property (
		rd_setup && i_paddr == 12'h004 |=> o_prdata[1] == o_pslverr)
		else $error("pointer flag differs from error");
endmodule // tdr_checker

//--- tdr_apb_host.sv
// apb host model that sets the pointer and reads debug words
`timescale 1ns/1ps
module tdr_apb_host (
	// clock
	input wire i_core_clk,
	// apb requests and answers
	output logic o_psel = 1'b0,
	output logic o_penable = 1'b0,
	output logic o_pwrite = 1'b0,
	output logic [11:0] o_paddr = 12'h000,
	output logic [31:0] o_pwdata = 32'h0,
	input wire [31:0] i_prdata,
	input wire i_pready,
	input wire i_pslverr
);
	// setup, access, take the answer at the ready edge, then release
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge i_core_clk);
		#1 o_psel = 1'b1;
		o_pwrite = w;
		o_paddr = a;
		o_pwdata = d;
		@(posedge i_core_clk);
		#1 o_penable = 1'b1;
		@(posedge i_core_clk iff i_pready);
		r = i_prdata;
		e = i_pslverr;
		#1 o_psel = 1'b0;
		o_penable = 1'b0;
		o_paddr = ~a;
		o_pwdata = ~d;
	endtask
endmodule // tdr_apb_host

//--- testbench.sv
// self-checking bench of the debug readout
`timescale 1ns/1ps
module testbench;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	wire i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
	wire [11:0] i_paddr;
	wire [31:0] i_pwdata, o_prdata;
	logic i_fill_we = 1'b0;
	logic i_fill_valid = 1'b0;
	logic [6:0] i_fill_index = 7'h00;
	logic [27:0] i_fill_va = 28'h0;
	logic [2:0] i_fill_page_size = 3'h0;
	logic [21:0] cfg = 22'h0;
	logic [2:0] pgs [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6};
	logic [31:0] rd;
	logic er;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	tdr_debug_readout dut_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
		.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_fill_we(i_fill_we), .i_fill_index(i_fill_index),
		.i_fill_valid(i_fill_valid), .i_fill_va(i_fill_va),
		.i_fill_page_size(i_fill_page_size),
		.i_fill_privilege_config(cfg[21:20]),
		.i_fill_instruction_config(cfg[19:18]),
		.i_fill_nonsecure_config(cfg[17:16]), .i_fill_mem_attr(cfg[15:9]),
		.i_fill_shareability_config(cfg[8:6]),
		.i_fill_read_allocate_config(cfg[5:4]),
		.i_fill_write_allocate_config(cfg[3:2]),
		.i_fill_barrier_share_attr(cfg[1:0]));
	tdr_apb_host host_u (.i_core_clk, .o_psel(i_psel), .o_penable(i_penable),
		.o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata),
		.i_prdata(o_prdata), .i_pready(o_pready), .i_pslverr(o_pslverr));
	// clock
	initial begin
		forever #2 i_core_clk = ~i_core_clk;
	end
	// cycle ceiling against a hang
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// read one register, compare data and error
	task automatic rd_chk(logic [11:0] a, logic [31:0] e, logic ee);
		host_u.xfer(1'b0, a, 32'h0, rd, er);
		chk("prdata", e, rd);
		chk("pslverr", {31'h0, ee}, {31'h0, er});
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		host_u.xfer(1'b1, a, d, rd, er);
	endtask
	// store one entry through the fill port
	task automatic fill(logic [6:0] x, logic v, logic [27:0] va,
		logic [2:0] pg, logic [21:0] c);
		@(posedge i_core_clk);
		#1 i_fill_we = 1'b1;
		i_fill_index = x;
		i_fill_valid = v;
		i_fill_va = va;
		i_fill_page_size = pg;
		cfg = c;
		@(posedge i_core_clk);
		#1 i_fill_we = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checked %0d failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge i_core_clk);
		#1 i_resetn = 1'b1;
		rd_chk(12'h000, 32'h0, 1'b0);
		wr(12'h000, 32'h13);
		rd_chk(12'h000, 32'h10, 1'b0);
		fill(7'h00, 1'b1, 28'h89abcde, 3'h3, 22'h2aaaaa);
		fill(7'h05, 1'b0, 28'h1234567, 3'h0, 22'h155555);
		wr(12'h000, 32'h0);
		rd_chk(12'h004, {28'h89abcde, 4'h9}, 1'b0);
		rd_chk(12'h004, {2'h0, 22'h2aaaaa, 8'h30}, 1'b0);
		rd_chk(12'h004, 32'h0, 1'b0);
		rd_chk(12'h004, 32'h8, 1'b0);
		rd_chk(12'h000, 32'h10, 1'b0);
		wr(12'h000, 32'h50);
		rd_chk(12'h004, {28'h1234567, 4'h5}, 1'b0);
		rd_chk(12'h004, {2'h0, 22'h155555, 8'h04}, 1'b0);
		$display("walk test done");
		foreach (pgs[k]) begin
			fill(7'h7f, 1'b1, 28'h0, pgs[k], 22'h0);
			wr(12'h000, 32'h7f4);
			rd_chk(12'h004, {25'h0, pgs[k], 4'h0}, 1'b0);
		end
		$display("page size test done");
		wr(12'h000, 32'h800);
		rd_chk(12'h004, 32'h6, 1'b1);
		rd_chk(12'h000, 32'h804, 1'b0);
		wr(12'h000, 32'h10000);
		rd_chk(12'h004, 32'h6, 1'b1);
		rd_chk(12'h000, 32'h10004, 1'b0);
		rd_chk(12'h008, 32'h0, 1'b0);
		$display("bounds test done");
		report_and_stop();
	end
endmodule // testbench
bind tdr_debug_readout tdr_checker chk_u (.i_core_clk(i_core_clk),
	.i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr));
